// >>> src/pwr_mode_ctrl.sv
// Normal/Slow/Sleep mode controller with wake-up sources and start-up delays.
// Assumes the core pulses halt and clear-watchdog for one cycle, and that
// pins, interrupt flags and options are synchronous to mclk.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

// Contract
// - Slow crystal only with fast internal RC
// - Fast crystal or external RC disables slow crystal
// - Clock-mode bit acts only in combined configuration
// - Normal: both run; Slow: fast RC stopped
// - Sleep stops fast clock; slow crystal runs
// - Halt enters Sleep whatever the clock mode
// - Sleep holds execution and all state
// - Sleep clears watchdog; stops if system-clocked
// - Halt sets power-down, clears time-out flag
// - Wake on reset, pin edge, interrupt, watchdog
// - Reset wake resets fully; watchdog wake resets PC/SP
// - Power-down cleared by power-up or clear-watchdog
// - Watchdog wake sets time-out, resets PC/SP only
// - Enabled pin falling edge wakes, resumes after halt
// - Disabled or stack-full interrupt resumes after halt
// - Enabled interrupt with free stack is serviced
// - Flag already set before Sleep cannot wake
// - Wake delay: start-up, plus reset delay
// - Reset delay is 100 ms power-on delay
// - Crystal low-power bit: 0 quick, 1 low power
module pwr_mode_ctrl #(
	parameter int unsigned N_IRQ              = 4,
	parameter int unsigned RESET_DELAY_CYCLES = pwr_mode_pkg::RESET_DELAY_CYC,
	parameter bit          SHORT_RC_START     = 1'b0
) (
	// Clock and power-on reset
	input  wire logic                   mclk,
	input  wire logic                   rst_n,
	// Register port
	input  wire pwr_mode_pkg::avl_req_t avl,
	output logic [31:0]                 avl_readdata,
	output logic                        avl_waitrequest,
	// Configuration options
	input  wire pwr_mode_pkg::osc_cfg_t osc_cfg,
	input  wire pwr_mode_pkg::wdt_src_t wdt_src,
	// Core events
	input  wire logic                   halt_exec,
	input  wire logic                   clr_wdt_exec,
	input  wire logic                   ext_reset_req,
	input  wire logic                   wdt_overflow,
	input  wire logic                   stack_full,
	input  wire logic [7:0]             port_pins,
	input  wire logic [N_IRQ-1:0]       irq_req,
	input  wire logic [N_IRQ-1:0]       irq_enable,
	// Clock steering
	output logic                        fast_osc_run,
	output logic                        slow_osc_run,
	output logic                        sys_clk_slow,
	output logic                        slow_xtal_low_power,
	// Core control
	output logic                        cpu_hold,
	output logic                        wdt_clear,
	output logic                        wdt_run,
	output logic                        full_reset,
	output logic                        pc_sp_reset,
	output logic                        irq_take,
	output logic                        resume_next
);
	import pwr_mode_pkg::*;

	localparam logic [DELAY_CNT_W-1:0] RST_DLY   = DELAY_CNT_W'(RESET_DELAY_CYCLES);
	localparam logic [DELAY_CNT_W-1:0] DLY_RC_S  = DELAY_CNT_W'(START_RC_SHORT);
	localparam logic [DELAY_CNT_W-1:0] DLY_RC_L  = DELAY_CNT_W'(START_RC_LONG);
	localparam logic [DELAY_CNT_W-1:0] DLY_XTAL  = DELAY_CNT_W'(START_CRYSTAL);

	// Address decode shared by read and write paths
	function automatic reg_sel_t reg_decode(input logic [3:0] addr);
		case (addr)
			ADDR_CONTROL_REGISTER_ZERO:     reg_decode = SEL_CONTROL_REGISTER_ZERO;
			ADDR_STATUS:    reg_decode = SEL_STATUS;
			ADDR_PORT_WAKE: reg_decode = SEL_PORT_WAKE;
			default:        reg_decode = SEL_NONE;
		endcase
	endfunction : reg_decode

	pwr_state_t                 state_reg;
	pwr_state_t                 state_next;
	wake_cause_t                cause_reg;
	wake_cause_t                cause_next;
	logic                       clock_mode_select_reg;
	logic                       power_down_flag_reg;
	logic                       watchdog_timeout_flag_reg;
	logic [7:0]                 port_wake_enable_reg;
	logic [7:0]                 pin_prev_reg;
	logic [N_IRQ-1:0]           irq_premask_reg;
	logic [N_IRQ-1:0]           irq_hit_reg;
	logic                       comb_cfg;
	logic                       slow_sel;
	logic                       wr_go;
	logic                       wake_pin;
	logic                       wake_irq;
	logic                       wake_wdt;
	logic                       any_wake;
	logic                       start_delay;
	logic                       delay_done;
	logic [DELAY_CNT_W-1:0]     startup_load;
	logic [DELAY_CNT_W-1:0]     delay_load;
	logic [N_IRQ-1:0]           irq_new;

	// Clock source qualification
	assign comb_cfg = (osc_cfg == OSC_FAST_RC_SLOW);
	assign slow_sel = clock_mode_select_reg && comb_cfg;

	// Wake sources; flags set before Sleep are masked out
	assign irq_new  = irq_req & ~irq_premask_reg;
	assign wake_irq = |irq_new;
	assign wake_pin = |(pin_prev_reg & ~port_pins & port_wake_enable_reg);
	assign wake_wdt = wdt_overflow && (wdt_src != WDT_SRC_SYS);
	assign any_wake = ext_reset_req || wake_wdt || wake_pin || wake_irq;
	assign start_delay = (state_reg == ST_SLEEP && any_wake) ||
		(state_reg == ST_RUN && ext_reset_req);

	// Start-up time depends on the fast oscillator type
	assign startup_load = (osc_cfg == OSC_FAST_XTAL) ? DLY_XTAL :
		(SHORT_RC_START ? DLY_RC_S : DLY_RC_L);
	assign delay_load = ext_reset_req ? (startup_load + RST_DLY) : startup_load;

	// Wake cause with reset first, then watchdog, pin, interrupt
	always_comb begin
		cause_next = cause_reg;
		if (start_delay) begin
			if (ext_reset_req) begin
				cause_next = CAUSE_EXT;
			end else if (wake_wdt) begin
				cause_next = CAUSE_WDT;
			end else if (wake_pin) begin
				cause_next = CAUSE_PIN;
			end else begin
				cause_next = CAUSE_IRQ;
			end
		end
	end

	// Mode sequencing
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_RUN: begin
				if (ext_reset_req) begin
					state_next = ST_WAKE;
				end else if (halt_exec) begin
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (any_wake) begin
					state_next = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (delay_done) begin
					state_next = ST_RUN;
				end
			end
			default: state_next = ST_RUN;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= ST_RUN;
			cause_reg <= CAUSE_NONE;
		end else begin
			state_reg <= state_next;
			cause_reg <= cause_next;
		end
	end

	// Start-up and reset delay timer
	startup_timer #(
		.CNT_W (DELAY_CNT_W)
	) u_timer (
		.mclk  (mclk),
		.rst_n (rst_n),
		.start (start_delay),
		.load  (delay_load),
		.done  (delay_done)
	);

	// Edge history and interrupt snapshot at Sleep entry
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev_reg    <= PORT_WAKE_RST;
			irq_premask_reg <= '0;
			irq_hit_reg     <= '0;
		end else begin
			pin_prev_reg <= port_pins;
			if (state_reg == ST_RUN && halt_exec) begin
				irq_premask_reg <= irq_req;
			end else if (state_reg != ST_SLEEP) begin
				irq_premask_reg <= '0;
			end
			if (state_reg == ST_SLEEP && any_wake) begin
				irq_hit_reg <= irq_new;
			end
		end
	end

	// Status flags; halt wins over a clear in the same cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			power_down_flag_reg       <= 1'b0;
			watchdog_timeout_flag_reg <= 1'b0;
		end else begin
			if (state_reg == ST_RUN && halt_exec) begin
				power_down_flag_reg       <= 1'b1;
				watchdog_timeout_flag_reg <= 1'b0;
			end else if (clr_wdt_exec) begin
				power_down_flag_reg <= 1'b0;
			end
			// A timeout in the halt cycle still lands; the set wins over the clear
			if (wake_wdt || (state_reg == ST_RUN && wdt_overflow)) begin
				watchdog_timeout_flag_reg <= 1'b1;
			end
		end
	end

	// Clock steering follows the next state so outputs align with it
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fast_osc_run <= 1'b1;
			slow_osc_run <= 1'b0;
			sys_clk_slow <= 1'b0;
		end else begin
			// Fast RC off in Slow and Sleep; it must run through start-up
			fast_osc_run <= (state_next == ST_WAKE) ||
				(state_next == ST_RUN && !slow_sel);
			slow_osc_run <= comb_cfg;
			sys_clk_slow <= slow_sel && state_next == ST_RUN;
		end
	end

	// Core hold and watchdog steering
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cpu_hold  <= 1'b0;
			wdt_clear <= 1'b0;
			wdt_run   <= 1'b1;
		end else begin
			cpu_hold  <= (state_next != ST_RUN);
			wdt_clear <= (state_reg == ST_RUN && halt_exec);
			wdt_run   <= (state_next != ST_SLEEP) || (wdt_src != WDT_SRC_SYS);
		end
	end

	// Actions at the end of the wake delay, one-cycle pulses
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			full_reset  <= 1'b0;
			pc_sp_reset <= 1'b0;
			irq_take    <= 1'b0;
			resume_next <= 1'b0;
		end else begin
			full_reset  <= 1'b0;
			pc_sp_reset <= 1'b0;
			irq_take    <= 1'b0;
			resume_next <= 1'b0;
			if (state_reg == ST_WAKE && delay_done) begin
				case (cause_reg)
					CAUSE_EXT: full_reset  <= 1'b1;
					CAUSE_WDT: pc_sp_reset <= 1'b1;
					CAUSE_PIN: resume_next <= 1'b1;
					CAUSE_IRQ: begin
						// Pending request stays set in its flag for later service
						if (|(irq_hit_reg & irq_enable) && !stack_full) begin
							irq_take <= 1'b1;
						end else begin
							resume_next <= 1'b1;
						end
					end
					default: resume_next <= 1'b1;
				endcase
			end
		end
	end

	// Avalon slave: one wait cycle, then a one-cycle answer
	assign wr_go = avl.write && !avl_waitrequest;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			avl_waitrequest <= 1'b1;
			avl_readdata    <= DATA_ZERO;
		end else begin
			avl_waitrequest <= !((avl.read || avl.write) && avl_waitrequest);
			if (avl.read && avl_waitrequest) begin
				avl_readdata <= DATA_ZERO;
				case (reg_decode(avl.address))
					SEL_CONTROL_REGISTER_ZERO: begin
						avl_readdata[BIT_CLK_MODE] <= clock_mode_select_reg;
						avl_readdata[BIT_XTAL_LP]  <= slow_xtal_low_power;
					end
					SEL_STATUS: begin
						avl_readdata[BIT_PDF]         <= power_down_flag_reg;
						avl_readdata[BIT_TO]          <= watchdog_timeout_flag_reg;
						avl_readdata[BIT_SLOW_ACTIVE] <= sys_clk_slow;
						avl_readdata[LSB_STATE +: 2]  <= state_reg;
						avl_readdata[LSB_CAUSE +: 3]  <= cause_reg;
					end
					SEL_PORT_WAKE: avl_readdata[7:0] <= port_wake_enable_reg;
					default:       avl_readdata <= DATA_ZERO;
				endcase
			end
		end
	end
	// Control register; both bits clear at power-on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			clock_mode_select_reg <= 1'b0;
			slow_xtal_low_power   <= 1'b0;
		end else if (wr_go && reg_decode(avl.address) == SEL_CONTROL_REGISTER_ZERO) begin
			clock_mode_select_reg <= avl.writedata[BIT_CLK_MODE];
			slow_xtal_low_power   <= avl.writedata[BIT_XTAL_LP];
		end
	end
	// Pin wake enables
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			port_wake_enable_reg <= PORT_WAKE_RST;
		end else if (wr_go && reg_decode(avl.address) == SEL_PORT_WAKE) begin
			port_wake_enable_reg <= avl.writedata[7:0];
		end
	end
	// Checks
	sequence s_halt_in_run;
		state_reg == ST_RUN && halt_exec && !ext_reset_req;
	endsequence
	sequence s_quiet_wake;
		state_reg == ST_SLEEP && any_wake && !ext_reset_req;
	endsequence
	a_halt_enters_sleep: assert property (@(posedge mclk) disable iff (!rst_n)
		s_halt_in_run |=> state_reg == ST_SLEEP && cpu_hold)
		else $error("halt did not enter sleep");
	a_halt_sets_flags: assert property (@(posedge mclk) disable iff (!rst_n)
		s_halt_in_run |=> power_down_flag_reg && wdt_clear
		&& watchdog_timeout_flag_reg == $past(wdt_overflow))
		else $error("halt flags wrong");
	a_clear_drops_pdf: assert property (@(posedge mclk) disable iff (!rst_n)
		clr_wdt_exec && !(state_reg == ST_RUN && halt_exec) |=> !power_down_flag_reg)
		else $error("power-down flag not cleared");
	a_sleep_fast_off: assert property (@(posedge mclk) disable iff (!rst_n)
		state_reg == ST_SLEEP |-> !fast_osc_run && slow_osc_run == $past(comb_cfg))
		else $error("fast clock runs in sleep");
	a_slow_mode_gated: assert property (@(posedge mclk) disable iff (!rst_n)
		sys_clk_slow |-> $past(comb_cfg) && $past(clock_mode_select_reg) && !fast_osc_run)
		else $error("slow clock selected outside combined mode");
	a_wdt_wake_flag: assert property (@(posedge mclk) disable iff (!rst_n)
		state_reg == ST_SLEEP && wake_wdt && !ext_reset_req
		|=> watchdog_timeout_flag_reg && state_reg == ST_WAKE && cause_reg == CAUSE_WDT)
		else $error("watchdog wake not taken");
	a_premask_no_wake: assert property (@(posedge mclk) disable iff (!rst_n)
		state_reg == ST_SLEEP && !ext_reset_req && !wake_wdt && !wake_pin
		&& (irq_req & ~irq_premask_reg) == '0 |=> state_reg == ST_SLEEP)
		else $error("masked interrupt woke the device");
	a_quiet_wake_delay: assert property (@(posedge mclk) disable iff (!rst_n)
		s_quiet_wake ##1 state_reg == ST_WAKE |-> ##[1:130] state_reg == ST_RUN)
		else $error("start-up delay too long");
	// The action pulse and the return to run share one edge
	a_wake_action: assert property (@(posedge mclk) disable iff (!rst_n)
		state_reg == ST_WAKE ##1 state_reg == ST_RUN
		|-> irq_take || resume_next || full_reset || pc_sp_reset)
		else $error("wake ended without an action");

endmodule : pwr_mode_ctrl

// >>> src/pwr_mode_pkg.sv
// Constants, types and register map for the operating-mode controller.
// Assumes a 200 MHz mclk and a word-aligned Avalon-MM register port.
package pwr_mode_pkg;

	// Clock and timing
	localparam int unsigned CLK_HZ           = 200_000_000;
	localparam int unsigned CLK_PER_MS       = CLK_HZ / 1000;
	localparam int unsigned RESET_DELAY_MS   = 100;
	localparam int unsigned RESET_DELAY_CYC  = RESET_DELAY_MS * CLK_PER_MS;
	localparam int unsigned START_RC_SHORT   = 2;
	localparam int unsigned START_RC_LONG    = 128;
	localparam int unsigned START_CRYSTAL    = 128;
	localparam int unsigned DELAY_CNT_W      = 26;

	// Register byte addresses
	localparam logic [3:0]  ADDR_CONTROL_REGISTER_ZERO       = 4'h0;
	localparam logic [3:0]  ADDR_STATUS      = 4'h4;
	localparam logic [3:0]  ADDR_PORT_WAKE   = 4'h8;

	// Field positions
	localparam int unsigned BIT_CLK_MODE     = 0;
	localparam int unsigned BIT_XTAL_LP      = 1;
	localparam int unsigned BIT_PDF          = 0;
	localparam int unsigned BIT_TO           = 1;
	localparam int unsigned BIT_SLOW_ACTIVE  = 2;
	localparam int unsigned LSB_STATE        = 4;
	localparam int unsigned LSB_CAUSE        = 8;

	// Reset values
	localparam logic [7:0]  PORT_WAKE_RST    = 8'h00;
	localparam logic [31:0] DATA_ZERO        = 32'h0000_0000;

	// Oscillator configuration option
	typedef enum logic [1:0] {
		OSC_FAST_XTAL     = 2'b00,
		OSC_EXT_RC        = 2'b01,
		OSC_FAST_RC       = 2'b10,
		OSC_FAST_RC_SLOW  = 2'b11
	} osc_cfg_t;

	// Watchdog clock source option
	typedef enum logic [1:0] {
		WDT_SRC_SYS       = 2'b00,
		WDT_SRC_SLOW_RC   = 2'b01,
		WDT_SRC_SLOW_XTAL = 2'b10
	} wdt_src_t;

	// Controller states
	typedef enum logic [1:0] {
		ST_RUN            = 2'b00,
		ST_SLEEP          = 2'b01,
		ST_WAKE           = 2'b10
	} pwr_state_t;

	// Last wake-up source
	typedef enum logic [2:0] {
		CAUSE_NONE        = 3'b000,
		CAUSE_EXT         = 3'b001,
		CAUSE_WDT         = 3'b010,
		CAUSE_PIN         = 3'b011,
		CAUSE_IRQ         = 3'b100
	} wake_cause_t;

	// Register select
	typedef enum logic [1:0] {
		SEL_CONTROL_REGISTER_ZERO         = 2'b00,
		SEL_STATUS        = 2'b01,
		SEL_PORT_WAKE     = 2'b10,
		SEL_NONE          = 2'b11
	} reg_sel_t;

	// Avalon-MM request from the master
	typedef struct packed {
		logic [3:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} avl_req_t;

endpackage : pwr_mode_pkg

// >>> src/startup_timer.sv
// Down-counter that times the start-up and reset delays after a wake event.
// Assumes start is a one-cycle pulse and load is at least one.
`timescale 1ns/1ps
module startup_timer #(
	parameter int unsigned CNT_W = 26
) (
	// Clock and reset
	input  wire logic             mclk,
	input  wire logic             rst_n,
	// Control
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] load,
	// Result
	output logic                  done
);
	import pwr_mode_pkg::*;

	localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

	logic [CNT_W-1:0] count_reg;

	// Count down from the load value; a new start restarts the count
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= '0;
		end else if (start) begin
			count_reg <= load;
		end else if (count_reg != '0) begin
			count_reg <= count_reg - CNT_ONE;
		end
	end

	// Done pulses exactly load cycles after the start edge
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else begin
			done <= !start && (count_reg == CNT_ONE);
		end
	end

endmodule : startup_timer

// >>> tb/operating_mode_sleep_wake_control_test.sv
// Self-checking bench for the mode controller: modes, Sleep entry, wakes.
// Assumes the partner model drives reset line and pins; reset delay is cut.
`timescale 1ns/1ps
module operating_mode_sleep_wake_control_test;
	import pwr_mode_pkg::*;
	localparam int unsigned RST_CYC = 20;
	// Start-up count plus drive, pulse and sampling edges
	localparam int          T_WAKE  = START_RC_LONG + 3;
	logic             mclk;
	logic             rst_n;
	avl_req_t         avl;
	logic [31:0]      avl_readdata;
	logic             avl_waitrequest;
	osc_cfg_t         osc_cfg;
	wdt_src_t         wdt_src;
	logic             halt_exec;
	logic             clr_wdt_exec;
	logic             ext_reset_req;
	logic             wdt_overflow;
	logic             stack_full;
	logic [7:0]       port_pins;
	logic [3:0]       irq_req;
	logic [3:0]       irq_enable;
	logic             fast_osc_run;
	logic             slow_osc_run;
	logic             sys_clk_slow;
	logic             slow_xtal_low_power;
	logic             cpu_hold;
	logic             wdt_clear;
	logic             wdt_run;
	logic             full_reset;
	logic             pc_sp_reset;
	logic             irq_take;
	logic             resume_next;
	logic [3:0]       act;
	logic [31:0]      q;
	int               n;
	int               errors;
	int               check_count;
	// Action pulses: 0 resume, 1 irq, 2 pc/sp reset, 3 full reset
	assign act = {full_reset, pc_sp_reset, irq_take, resume_next};
	pwr_mode_ctrl #(.N_IRQ(4), .RESET_DELAY_CYCLES(RST_CYC), .SHORT_RC_START(1'b0)) i_dut (
		.mclk(mclk), .rst_n(rst_n), .avl(avl), .avl_readdata(avl_readdata),
		.avl_waitrequest(avl_waitrequest), .osc_cfg(osc_cfg), .wdt_src(wdt_src),
		.halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec), .ext_reset_req(ext_reset_req),
		.wdt_overflow(wdt_overflow), .stack_full(stack_full), .port_pins(port_pins),
		.irq_req(irq_req), .irq_enable(irq_enable), .fast_osc_run(fast_osc_run),
		.slow_osc_run(slow_osc_run), .sys_clk_slow(sys_clk_slow),
		.slow_xtal_low_power(slow_xtal_low_power), .cpu_hold(cpu_hold),
		.wdt_clear(wdt_clear), .wdt_run(wdt_run), .full_reset(full_reset),
		.pc_sp_reset(pc_sp_reset), .irq_take(irq_take), .resume_next(resume_next));
	wake_partner i_partner (.mclk(mclk), .ext_reset_req(ext_reset_req), .port_pins(port_pins));
	// Clock at 200 MHz
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// Core event strobes are one cycle wide, so they clear themselves
	always @(posedge mclk) begin
		if (halt_exec) halt_exec <= 1'b0;
		if (clr_wdt_exec) clr_wdt_exec <= 1'b0;
		if (wdt_overflow) wdt_overflow <= 1'b0;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// One Avalon cycle; waits for waitrequest low, takes data at that edge
	// No cycle limit here: only the bench watchdog ends a stuck wait
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avl <= '{address: a, read: !wr, write: wr, writedata: d};
		do begin
			@(posedge mclk);
		end while (avl_waitrequest !== 1'b0);
		q = avl_readdata;
		avl <= '0;
	endtask : bus
	task automatic go_sleep();
		@(posedge mclk);
		halt_exec <= 1'b1;
		repeat (2) @(posedge mclk);
		check(wdt_clear, 1);
		@(posedge mclk);
	endtask : go_sleep
	// Cycles from the event drive until the chosen action pulse
	task automatic wait_act(input int idx);
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (act[idx] !== 1'b1 && n < 400);
	endtask : wait_act
	task automatic t_reset();
		bus(0, ADDR_CONTROL_REGISTER_ZERO, 0);
		check(q, 0);
		bus(0, ADDR_PORT_WAKE, 0);
		check(q, 0);
		bus(0, 4'hc, 0);
		check(q, 0);
		check(sys_clk_slow, 0);
		$display("test reset done");
	endtask : t_reset
	task automatic t_modes();
		bus(1, ADDR_CONTROL_REGISTER_ZERO, 3);
		repeat (3) @(posedge mclk);
		check({sys_clk_slow, fast_osc_run, slow_osc_run}, 3'b101);
		check(slow_xtal_low_power, 1);
		osc_cfg <= OSC_FAST_RC;
		repeat (3) @(posedge mclk);
		check({sys_clk_slow, slow_osc_run}, 2'b00);
		osc_cfg <= OSC_FAST_XTAL;
		repeat (3) @(posedge mclk);
		check(slow_osc_run, 0);
		osc_cfg <= OSC_FAST_RC_SLOW;
		repeat (3) @(posedge mclk);
		check(sys_clk_slow, 1);
		$display("test modes done");
	endtask : t_modes
	task automatic t_pin();
		bus(1, ADDR_PORT_WAKE, 32'h0000_0008);
		go_sleep();
		check({cpu_hold, fast_osc_run, slow_osc_run, wdt_run}, 4'b1010);
		bus(0, ADDR_STATUS, 0);
		check({q[5:4], q[1:0]}, 4'b0101);
		i_partner.pins(8'hfb);
		repeat (5) @(posedge mclk);
		check(cpu_hold, 1);
		i_partner.pins(8'hf3);
		wait_act(0);
		check(n, T_WAKE);
		i_partner.pins(8'hff);
		bus(0, ADDR_CONTROL_REGISTER_ZERO, 0);
		check(q, 3);
		$display("test pin wake done");
	endtask : t_pin
	task automatic t_wdt();
		@(posedge mclk);
		clr_wdt_exec <= 1'b1;
		bus(0, ADDR_STATUS, 0);
		check(q[0], 0);
		wdt_src <= WDT_SRC_SLOW_RC;
		go_sleep();
		check(wdt_run, 1);
		@(posedge mclk);
		wdt_overflow <= 1'b1;
		wait_act(2);
		check(n, T_WAKE);
		bus(0, ADDR_STATUS, 0);
		check(q[1:0], 2'b11);
		$display("test watchdog wake done");
	endtask : t_wdt
	task automatic t_irq();
		irq_enable <= 4'b0011;
		irq_req    <= 4'b0001;
		go_sleep();
		irq_req <= 4'b0000;
		@(posedge mclk);
		irq_req <= 4'b0001;
		repeat (5) @(posedge mclk);
		check(cpu_hold, 1);
		irq_req <= 4'b0011;
		wait_act(1);
		check(n, T_WAKE);
		irq_req <= 4'b0000;
		go_sleep();
		irq_req <= 4'b0100;
		wait_act(0);
		check(n, T_WAKE);
		irq_req    <= 4'b0000;
		stack_full <= 1'b1;
		go_sleep();
		irq_req <= 4'b0010;
		wait_act(0);
		check(n, T_WAKE);
		$display("test interrupt wake done");
	endtask : t_irq
	task automatic t_ext();
		go_sleep();
		i_partner.reset_pulse();
		wait_act(3);
		check(n, T_WAKE + RST_CYC);
		$display("test reset wake done");
	endtask : t_ext
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict
	// Watchdog: the whole run needs well under 3000 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		errors++;
		print_verdict();
	end
	// Main sequence
	initial begin
		errors       = 0;
		check_count  = 0;
		rst_n        = 1'b0;
		avl          = '0;
		osc_cfg      = OSC_FAST_RC_SLOW;
		wdt_src      = WDT_SRC_SYS;
		halt_exec    = 1'b0;
		clr_wdt_exec = 1'b0;
		wdt_overflow = 1'b0;
		stack_full   = 1'b0;
		irq_req      = 4'h0;
		irq_enable   = 4'h0;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		t_reset();
		t_modes();
		t_pin();
		t_wdt();
		t_irq();
		t_ext();
		print_verdict();
	end
endmodule : operating_mode_sleep_wake_control_test

// >>> tb/wake_partner.sv
// Far-side model: external reset line and the eight wake-capable port pins.
// Assumes the bench calls its tasks from a process that follows mclk.
`timescale 1ns/1ps
module wake_partner (
	// Clock
	input  wire logic  mclk,
	// Lines towards the controller
	output logic       ext_reset_req,
	output logic [7:0] port_pins
);
	// Pins idle high on pull-ups, so a fall only comes from a driven low
	initial begin
		ext_reset_req = 1'b0;
		port_pins     = 8'hff;
	end
	// Reset request is a one-cycle pulse; self-clearing avoids a double drive
	always @(posedge mclk) begin
		if (ext_reset_req) begin
			ext_reset_req <= 1'b0;
		end
	end
	// Drive pin levels right after an edge; a 1 releases to the pull-up
	task automatic pins(input logic [7:0] v);
		@(posedge mclk);
		port_pins <= v;
	endtask : pins
	// External reset event
	task automatic reset_pulse();
		@(posedge mclk);
		ext_reset_req <= 1'b1;
	endtask : reset_pulse
endmodule : wake_partner
